// ===== rtl/dio_channel_protection_control.sv
`timescale 1ns/1ps
`default_nettype none

module dio_channel_protection_control #(
    parameter int unsigned HOLD_CYCLES = dio_pkg::HOLD_CYCLES
) (
    input  wire logic                       clk_i,                  // Module clock
    input  wire logic                       rst_i,                  // Sync reset
    input  wire logic                       wb_cyc_i,               // Wishbone cycle
    input  wire logic                       wb_stb_i,               // Wishbone strobe
    input  wire logic                       wb_we_i,                // Write enable
    input  wire logic [dio_pkg::ADR_W-1:0]  wb_adr_i,               // Byte address
    input  wire logic [3:0]                 wb_sel_i,               // Byte enables
    input  wire logic [31:0]                wb_dat_i,               // Write data
    output logic [31:0]                     wb_dat_o,               // Read data
    output logic                            wb_ack_o,               // Acknowledge
    input  wire logic [dio_pkg::NUM_CH-1:0] rear_digital_line_i,    // Rear pin level
    output logic [dio_pkg::NUM_CH-1:0]      rear_digital_line_o,    // Rear pin drive
    output logic [dio_pkg::NUM_CH-1:0]      rear_digital_line_oe_o, // Rear drive enable
    input  wire logic [dio_pkg::NUM_CH-1:0] front_port_line_i,      // Front pin level
    output logic [dio_pkg::NUM_CH-1:0]      front_port_line_o,      // Front pin drive
    output logic [dio_pkg::NUM_CH-1:0]      front_port_line_oe_o,   // Front drive enable
    output logic [dio_pkg::NUM_CH-1:0]      switch_close_o,         // Disconnect switch closed
    input  wire logic [dio_pkg::NUM_CH-1:0] short_fault_i,          // Short detector
    input  wire logic [dio_pkg::NUM_CH-1:0] overvoltage_fault_i,    // Overvoltage detector
    output logic                            fault_o                 // Shared fault indicator
);

    localparam int N = dio_pkg::NUM_CH;

    // ==========================================================
    // Declarations
    // ==========================================================
    dio_pkg::chan_cfg_t        cfg_ff;
    dio_pkg::chan_cfg_t        nxt_cfg;
    dio_pkg::chan_cfg_t        pon_ff;
    dio_pkg::chan_cfg_t        nxt_pon;
    logic                      fault_ff;
    logic                      nxt_fault;
    logic                      ack_ff;
    logic                      nxt_ack;
    logic [31:0]               dat_ff;
    logic [31:0]               nxt_dat;
    logic [dio_pkg::SYNC_W-1:0] s1_ff;
    logic [dio_pkg::SYNC_W-1:0] s2_ff;
    logic [dio_pkg::SYNC_W-1:0] s3_ff;
    logic [dio_pkg::SYNC_W-1:0] val_ff;
    logic [dio_pkg::SYNC_W-1:0] nxt_val;
    logic [N-1:0]              rear_s;
    logic [N-1:0]              front_s;
    logic [N-1:0]              short_s;
    logic [N-1:0]              ovp_s;
    logic [N-1:0]              hold;
    logic [N-1:0]              short_trip;
    logic [N-1:0]              ovp_trip;
    logic [N-1:0]              trip;
    logic [N-1:0]              valid_front;
    logic [N-1:0]              front_o_ff;
    logic [N-1:0]              nxt_front_o;
    logic [N-1:0]              rear_o_ff;
    logic [N-1:0]              nxt_rear_o;
    logic                      bus_req;
    logic                      bus_wr;
    logic [dio_pkg::ADR_W-1:0] adr;

    // Byte-lane merge for 32-bit registers
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    // A bit changes once stages two and three agree; filters one-cycle glitches
    always_comb begin
        nxt_val = (s2_ff & s3_ff) | (val_ff & (s2_ff | s3_ff));
    end

    // Three-stage chain for pins and fault detectors
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_ff  <= '0;
            s2_ff  <= '0;
            s3_ff  <= '0;
            val_ff <= '0;
        end else begin
            s1_ff  <= {overvoltage_fault_i, short_fault_i, front_port_line_i, rear_digital_line_i};
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            val_ff <= nxt_val;
        end
    end

    assign rear_s  = val_ff[0 +: N];
    assign front_s = val_ff[N +: N];
    assign short_s = val_ff[2*N +: N];
    assign ovp_s   = val_ff[3*N +: N];

    // ==========================================================
    // Per-channel protection
    // ==========================================================
    // Channel index = bank*16 + port*8 + line, so banks and ports are bit slices
    genvar ch;
    generate
        for (ch = 0; ch < N; ch++) begin : g_ch
            // Short only matters on a driving output; overvoltage on any closed channel
            assign short_trip[ch] = short_s[ch] & cfg_ff.dir[ch] & switch_close_o[ch];
            assign ovp_trip[ch]   = ovp_s[ch] & switch_close_o[ch];
            assign trip[ch]       = short_trip[ch] | ovp_trip[ch];

            hiccup_timer #(
                .HOLD_CYCLES (HOLD_CYCLES)
            ) u_timer (
                .clk_i  (clk_i),
                .rst_i  (rst_i),
                .trip_i (trip[ch]),
                .hold_o (hold[ch])
            );

            // Protection overrides the software request
            assign switch_close_o[ch] = cfg_ff.conn[ch] & ~hold[ch];
            assign front_port_line_oe_o[ch] = switch_close_o[ch] & cfg_ff.dir[ch];
            assign rear_digital_line_oe_o[ch] = switch_close_o[ch] & ~cfg_ff.dir[ch];
            assign valid_front[ch] = front_s[ch] & switch_close_o[ch];
        end
    endgenerate

    // ==========================================================
    // Data path
    // ==========================================================
    // Held channels pass zero to the rear pins; front pin data is not gated by hold, only its drive enable
    always_comb begin
        nxt_front_o = rear_s & cfg_ff.dir;
        nxt_rear_o  = valid_front & ~cfg_ff.dir;
    end

    // Registered pin data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            front_o_ff <= '0;
            rear_o_ff  <= '0;
        end else begin
            front_o_ff <= nxt_front_o;
            rear_o_ff  <= nxt_rear_o;
        end
    end

    assign front_port_line_o   = front_o_ff;
    assign rear_digital_line_o = rear_o_ff;

    // ==========================================================
    // Wishbone register file
    // ==========================================================
    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign bus_wr  = bus_req & wb_we_i;
    assign adr     = {wb_adr_i[dio_pkg::ADR_W-1:2], 2'b00};

    // Decode, writes and read mux; unmapped offsets ack with zero
    always_comb begin
        nxt_cfg   = cfg_ff;
        nxt_pon   = pon_ff;
        nxt_fault = fault_ff;
        nxt_ack   = bus_req;
        nxt_dat   = '0;
        if (bus_wr) begin
            case (adr)
                dio_pkg::OFS_DIR: begin
                    nxt_cfg.dir = merge(cfg_ff.dir, wb_dat_i, wb_sel_i);
                end
                dio_pkg::OFS_CONN: begin
                    nxt_cfg.conn = merge(cfg_ff.conn, wb_dat_i, wb_sel_i);
                end
                dio_pkg::OFS_PON_DIR:  nxt_pon.dir  = merge(pon_ff.dir, wb_dat_i, wb_sel_i);
                dio_pkg::OFS_PON_CONN: nxt_pon.conn = merge(pon_ff.conn, wb_dat_i, wb_sel_i);
                dio_pkg::OFS_FAULT: begin
                    if (wb_sel_i[0] && wb_dat_i[dio_pkg::FAULT_BIT]) begin
                        nxt_fault = 1'b0;
                    end
                end
                dio_pkg::OFS_APPLY: begin
                    if (wb_sel_i[0] && wb_dat_i[dio_pkg::APPLY_BIT]) begin
                        nxt_cfg = pon_ff;
                    end
                end
                default: ;
            endcase
        end else if (bus_req) begin
            case (adr)
                dio_pkg::OFS_DIR:      nxt_dat = cfg_ff.dir;
                dio_pkg::OFS_CONN:     nxt_dat = cfg_ff.conn;
                dio_pkg::OFS_FAULT:    nxt_dat[dio_pkg::FAULT_BIT] = fault_ff;
                dio_pkg::OFS_HOLD:     nxt_dat = hold;
                dio_pkg::OFS_LINES:    nxt_dat = valid_front;
                dio_pkg::OFS_PON_DIR:  nxt_dat = pon_ff.dir;
                dio_pkg::OFS_PON_CONN: nxt_dat = pon_ff.conn;
                default:               nxt_dat = '0;
            endcase
        end
        // A new trip beats a clear in the same cycle
        if (|trip) begin
            nxt_fault = 1'b1;
        end
    end

    // Register file and bus answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_ff   <= '{dir: dio_pkg::DIR_RST, conn: dio_pkg::CONN_RST};
            pon_ff   <= '{dir: dio_pkg::DIR_RST, conn: dio_pkg::CONN_RST};
            fault_ff <= 1'b0;
            ack_ff   <= 1'b0;
            dat_ff   <= '0;
        end else begin
            cfg_ff   <= nxt_cfg;
            pon_ff   <= nxt_pon;
            fault_ff <= nxt_fault;
            ack_ff   <= nxt_ack;
            dat_ff   <= nxt_dat;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;
    assign fault_o  = fault_ff;

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Bus answer: one registered ack per request, data only beside it
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_follows: assert property (bus_req |=> wb_ack_o)
        else $error("request not acked next cycle");
    a_idle_data: assert property (!wb_ack_o |-> wb_dat_o == '0)
        else $error("read data shown without ack");

    // Start-up state, power-on copy and drive enables
    a_reset_isolated: assert property ($past(rst_i) |->
        switch_close_o == '0 && rear_digital_line_oe_o == '0)
        else $error("channel connected after reset");
    a_apply_copy: assert property (bus_wr && adr == dio_pkg::OFS_APPLY && wb_sel_i[0]
        && wb_dat_i[dio_pkg::APPLY_BIT] |=> cfg_ff == $past(pon_ff))
        else $error("power-on settings not applied");
    a_dir_drive: assert property (front_port_line_oe_o == (cfg_ff.dir & switch_close_o)
        && (front_port_line_oe_o & rear_digital_line_oe_o) == '0)
        else $error("drive enables disagree with direction");
    a_conn_write: assert property (bus_wr && adr == dio_pkg::OFS_CONN && wb_sel_i == 4'hf
        |=> cfg_ff.conn == $past(wb_dat_i))
        else $error("connect register not written");

    // Protection: a trip opens the switch next edge and starts its own timer
    a_short_open: assert property (|short_trip |=>
        (switch_close_o & $past(short_trip)) == '0)
        else $error("short did not open switch");
    a_ovp_open: assert property (|ovp_trip |=>
        (switch_close_o & $past(ovp_trip)) == '0)
        else $error("overvoltage did not open switch");
    a_trip_holds: assert property (|trip |=> (hold & $past(trip)) == $past(trip))
        else $error("trip did not start hold-off");
    a_invalid_zero: assert property ((valid_front & hold) == '0
        ##1 (rear_o_ff & $past(hold)) == '0)
        else $error("held channel passed data");

    // Shared fault bit: any trip sets it, only a write of one clears it
    a_fault_sets: assert property (|trip |=> fault_o)
        else $error("fault indicator not set on trip");
    a_fault_sticky: assert property (fault_o && !bus_wr |=> fault_o)
        else $error("fault indicator cleared without write");
    a_fault_clear: assert property (bus_wr && adr == dio_pkg::OFS_FAULT && wb_sel_i[0]
        && wb_dat_i[dio_pkg::FAULT_BIT] && trip == '0 |=> !fault_o)
        else $error("fault indicator not cleared by write");

    // Pin filter: a bit moves only once stages two and three agree
    a_sync_filter: assert property (1'b1 |=>
        ((val_ff ^ $past(s3_ff)) & ~$past(s2_ff ^ s3_ff)) == '0)
        else $error("filtered input took an unconfirmed value");

    // Main scenarios worth seeing in a run
    c_short_trip: cover property (|short_trip);
    c_ovp_trip: cover property (|ovp_trip);
    c_clear_race: cover property (bus_wr && adr == dio_pkg::OFS_FAULT && |trip);
    c_read_fault: cover property (bus_req && !wb_we_i && adr == dio_pkg::OFS_FAULT && fault_o);

endmodule

`default_nettype wire

// ===== rtl/dio_pkg.sv
`default_nettype none

package dio_pkg;

    // ==========================================================
    // Channel organisation
    // ==========================================================
    localparam int NUM_BANKS      = 2;
    localparam int PORTS_PER_BANK = 2;
    localparam int LINES_PER_PORT = 8;
    localparam int LINES_PER_BANK = PORTS_PER_BANK * LINES_PER_PORT;
    localparam int NUM_CH         = NUM_BANKS * LINES_PER_BANK;
    localparam int SYNC_W         = 4 * NUM_CH;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_HZ       = 40_000_000;
    localparam int HOLD_TIME_MS = 1000;
    localparam int HOLD_CYCLES  = (CLK_HZ / 1000) * HOLD_TIME_MS;
    localparam int CNT_W        = 26;

    // ==========================================================
    // Register map (byte offsets)
    // ==========================================================
    localparam int          ADR_W        = 8;
    localparam logic [7:0]  OFS_DIR      = 8'h00;
    localparam logic [7:0]  OFS_CONN     = 8'h04;
    localparam logic [7:0]  OFS_FAULT    = 8'h08;
    localparam logic [7:0]  OFS_HOLD     = 8'h0c;
    localparam logic [7:0]  OFS_LINES    = 8'h10;
    localparam logic [7:0]  OFS_PON_DIR  = 8'h14;
    localparam logic [7:0]  OFS_PON_CONN = 8'h18;
    localparam logic [7:0]  OFS_APPLY    = 8'h1c;
    localparam int          FAULT_BIT    = 0;
    localparam int          APPLY_BIT    = 0;
    localparam logic [31:0] DIR_RST      = 32'h0000_0000;
    localparam logic [31:0] CONN_RST     = 32'h0000_0000;

    // ==========================================================
    // Types
    // ==========================================================
    typedef struct packed {
        logic [NUM_CH-1:0] dir;
        logic [NUM_CH-1:0] conn;
    } chan_cfg_t;

    typedef enum logic [1:0] {
        T_IDLE = 2'b01,
        T_HOLD = 2'b10
    } hiccup_state_t;

endpackage

`default_nettype wire

// ===== rtl/hiccup_timer.sv
`timescale 1ns/1ps
`default_nettype none

module hiccup_timer #(
    parameter int unsigned HOLD_CYCLES = dio_pkg::HOLD_CYCLES
) (
    input  wire logic clk_i,   // Module clock
    input  wire logic rst_i,   // Sync reset, active high
    input  wire logic trip_i,  // Fault seen on a closed channel
    output logic      hold_o   // Channel held isolated
);

    localparam logic [dio_pkg::CNT_W-1:0] LAST = dio_pkg::CNT_W'(HOLD_CYCLES - 1);

    dio_pkg::hiccup_state_t     state_ff;
    dio_pkg::hiccup_state_t     nxt_state;
    logic [dio_pkg::CNT_W-1:0]  cnt_ff;
    logic [dio_pkg::CNT_W-1:0]  nxt_cnt;

    // ==========================================================
    // Hold-off sequencer
    // ==========================================================
    // Retry simply returns to idle; a fault still present trips again
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        unique case (state_ff)
            dio_pkg::T_IDLE: begin
                if (trip_i) begin
                    nxt_state = dio_pkg::T_HOLD;
                    nxt_cnt   = '0;
                end
            end
            dio_pkg::T_HOLD: begin
                if (cnt_ff == LAST) begin
                    nxt_state = dio_pkg::T_IDLE;
                end else begin
                    nxt_cnt = cnt_ff + 1'b1;
                end
            end
            default: nxt_state = dio_pkg::T_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= dio_pkg::T_IDLE;
            cnt_ff   <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    assign hold_o = (state_ff == dio_pkg::T_HOLD);

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_hold_stays: assert property (hold_o && cnt_ff != LAST |=>
        hold_o && cnt_ff == $past(cnt_ff) + 1'b1)
        else $error("hold ended before full hold-off");
    a_hold_release: assert property (hold_o && cnt_ff == LAST |=> !hold_o)
        else $error("hold did not release after hold-off");
    a_retrip_restart: assert property (!hold_o && trip_i |=> hold_o && cnt_ff == '0)
        else $error("trip did not restart hold-off");
    c_retry_retrip: cover property (hold_o ##1 !hold_o && trip_i ##1 hold_o);

endmodule

`default_nettype wire

// ===== tb/front_device_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Front-side device model
// ==========================================================
// Drives its own level on lines the block leaves undriven; a short draws
// current only while the block drives the line, as a real short would.
module front_device_model (
    input  wire logic [dio_pkg::NUM_CH-1:0] drive_i, // Block drive value
    input  wire logic [dio_pkg::NUM_CH-1:0] oe_i,    // Block drive enable
    input  wire logic [dio_pkg::NUM_CH-1:0] level_i, // Device own level
    input  wire logic [dio_pkg::NUM_CH-1:0] short_i, // Line tied to a rail
    input  wire logic [dio_pkg::NUM_CH-1:0] ov_i,    // Overstress applied
    output logic [dio_pkg::NUM_CH-1:0]      line_o,  // Wire level
    output logic [dio_pkg::NUM_CH-1:0]      short_o, // Short detector
    output logic [dio_pkg::NUM_CH-1:0]      ov_o     // Overvoltage detector
);
    // Wire level and detectors
    assign line_o  = (oe_i & drive_i) | (~oe_i & level_i);
    assign short_o = short_i & oe_i; // No current without drive
    assign ov_o    = ov_i;
endmodule

`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

module tb;
    // ==========================================================
    // Signals and instances
    // ==========================================================
    localparam int HOLD = 16; // Short hold-off keeps the run brief
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd_v;
    logic        wb_ack_o, fault_o;
    logic [31:0] rear_i = 32'h0, rear_o, rear_oe, front_in, front_o, front_oe, sw;
    logic [31:0] dev_level = 32'h0, dev_short = 32'h0, dev_ov = 32'h0, short_f, ov_f;
    int          errors = 0, num_checks = 0, cycles = 0;

    always #12.5 clk_i = ~clk_i;

    dio_channel_protection_control #(.HOLD_CYCLES(HOLD)) dio_channel_protection_control_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rear_digital_line_i(rear_i),
        .rear_digital_line_o(rear_o), .rear_digital_line_oe_o(rear_oe),
        .front_port_line_i(front_in), .front_port_line_o(front_o),
        .front_port_line_oe_o(front_oe), .switch_close_o(sw), .short_fault_i(short_f),
        .overvoltage_fault_i(ov_f), .fault_o(fault_o));

    front_device_model front_device_model_i (
        .drive_i(front_o), .oe_i(front_oe), .level_i(dev_level), .short_i(dev_short),
        .ov_i(dev_ov), .line_o(front_in), .short_o(short_f), .ov_o(ov_f));

    // ==========================================================
    // Bus and helper tasks
    // ==========================================================
    // Classic cycle: hold everything until ack is sampled, then one idle cycle
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      input logic [3:0] sel, output logic [31:0] rd);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        // No own limit: only the bench timeout ends a missing answer
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] d;
        wb(1'b1, adr, dat, 4'hf, d);
    endtask

    task automatic rd(input logic [7:0] adr);
        wb(1'b0, adr, 32'h0, 4'hf, rd_v);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // One trip, one timed hold-off, one re-trip while the fault stays
    task automatic hiccup(input int ch);
        int n;
        n = 0;
        while (sw[ch] !== 1'b0 && n < 10) begin
            @(posedge clk_i);
            n++;
        end
        `CHK(sw[ch], 1'b0)
        `CHK(fault_o, 1'b1)
        n = 0;
        while (sw[ch] !== 1'b1 && n < 4 * HOLD) begin
            @(posedge clk_i);
            n++;
        end
        `CHK(n, HOLD)
        n = 0;
        while (sw[ch] !== 1'b0 && n < 10) begin
            @(posedge clk_i);
            n++;
        end
        `CHK(sw[ch], 1'b0)
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_reset();
        `CHK({sw, front_oe, rear_oe}, 96'h0)
        `CHK(fault_o, 1'b0)
        rd(dio_pkg::OFS_DIR);
        `CHK(rd_v, dio_pkg::DIR_RST)
        rd(dio_pkg::OFS_CONN);
        `CHK(rd_v, dio_pkg::CONN_RST)
        rd(8'h40);
        `CHK(rd_v, 32'h0)
    endtask

    task automatic t_regs();
        wr(dio_pkg::OFS_DIR, 32'h0000_00ff);
        wr(dio_pkg::OFS_CONN, 32'hffff_ffff);
        `CHK(sw, 32'hffff_ffff)
        `CHK({front_oe, rear_oe}, 64'h0000_00ff_ffff_ff00)
        wb(1'b1, dio_pkg::OFS_CONN, 32'h0, 4'h4, rd_v);
        rd(dio_pkg::OFS_CONN);
        `CHK(rd_v, 32'hff00_ffff)
        `CHK(sw[19], 1'b0)
        wr(dio_pkg::OFS_CONN, 32'hffff_ffff);
    endtask

    task automatic t_data();
        rear_i    <= 32'ha5a5_5a5a;
        dev_level <= 32'h3c3c_c3c3;
        tick(10);
        `CHK(front_o, 32'h0000_005a)
        `CHK(rear_o, 32'h3c3c_c300)
        rd(dio_pkg::OFS_LINES);
        `CHK(rd_v, 32'h3c3c_c35a)
    endtask

    task automatic t_fault(input int ch, input logic ov);
        if (ov) dev_ov[ch] <= 1'b1;
        else dev_short[ch] <= 1'b1;
        hiccup(ch);
        rd(dio_pkg::OFS_HOLD);
        `CHK(rd_v, 32'h1 << ch)
        `CHK(rear_o[ch], 1'b0)
        dev_ov    <= 32'h0;
        dev_short <= 32'h0;
        tick(2 * HOLD + 20);
        `CHK(sw[ch], 1'b1)
        rd(dio_pkg::OFS_FAULT);
        `CHK(rd_v[dio_pkg::FAULT_BIT], 1'b1)
        wr(dio_pkg::OFS_FAULT, 32'h1);
        `CHK(fault_o, 1'b0)
    endtask

    task automatic t_apply();
        wr(dio_pkg::OFS_PON_DIR, 32'hffff_0000);
        wr(dio_pkg::OFS_PON_CONN, 32'h0000_ffff);
        wr(dio_pkg::OFS_APPLY, 32'h1);
        rd(dio_pkg::OFS_DIR);
        `CHK(rd_v, 32'hffff_0000)
        `CHK(sw, 32'h0000_ffff)
    endtask

    // ==========================================================
    // Run control
    // ==========================================================
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Timeout well above the few hundred cycles the run needs
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            final_report();
        end
    end

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_regs();
        t_data();
        t_fault(3, 1'b0);
        t_fault(20, 1'b1);
        t_apply();
        final_report();
    end
endmodule

`default_nettype wire
